// ---- half_bridge_spi_register_bank.sv ----
// Summary of operation
// RULE1 - after reset every control register holds all zeros.
// RULE2 - a command is sixteen bits, address byte first and then data byte.
// RULE3 - control bits change only when the host writes them over the serial port.
// RULE4 - with address bit 7 low the access is a read and the register is left unchanged.
// RULE5 - with address bit 7 high the data byte is stored into the addressed register.
// RULE6 - activation register 1 holds outputs 1 to 4 as pairs, low enable even bit, high enable odd bit.
// RULE7 - a set high enable turns the high switch on, a clear one keeps it off.
// RULE8 - a set low enable turns the low switch on, a clear one keeps it off.
// RULE9 - both enables of one half-bridge set turns both switches of that half-bridge off.
// RULE10 - overcurrent status a holds high and low flags of outputs 1 to 4 and clears on read.
// RULE11 - overcurrent status c holds the flags of outputs 9 to 12 in the same layout and clears on read.
// RULE12 - open-load status a holds high and low flags of outputs 1 to 4 and clears on read.
// RULE13 - open-load status b and c hold outputs 5 to 8 and 9 to 12 and clear on read.
// RULE14 - a flag cleared by a read sets again while its fault is still present.
`timescale 1ns/1ps
`include "half_bridge_cfg.svh"

module half_bridge_spi_register_bank
	import half_bridge_pkg::*;
#(
	// arbitrary neutral value
	parameter logic [2:0] PART_IDENTIFIER = 3'h1
)
(
	input wire logic clk_in,
	input wire logic rst_in,
	input wire logic spi_cs_n_in,
	input wire logic spi_sclk_in,
	input wire logic spi_sdi_in,
	output logic spi_sdo_out,
	output logic spi_sdo_oe_out,
	input wire logic [5:0] global_fault_in,
	input wire logic [23:0] oc_fault_in,
	input wire logic [23:0] ol_fault_in,
	output logic [3:0] high_switch_on_out,
	output logic [3:0] low_switch_on_out,
	output logic [7:0] freewheel_openload_out,
	output logic [5:0] freewheel_out
);

	logic [`SYNC_WIDTH-1:0] raw_in;
	logic [`SYNC_WIDTH-1:0] s1_q;
	logic [`SYNC_WIDTH-1:0] s2_q;
	logic [`SYNC_WIDTH-1:0] s3_q;
	logic [`SYNC_WIDTH-1:0] filt_q;
	logic [`SYNC_WIDTH-1:0] filt_d;
	logic cs_n;
	logic sclk;
	logic sdi;
	logic sclk_prev_q;
	logic cs_n_prev_q;
	logic sclk_rise;
	logic sclk_fall;
	logic cs_fall;
	logic cs_rise;
	bit_count_t cnt_q;
	reg_byte_t rx_q;
	reg_byte_t addr_q;
	logic [15:0] tx_q;
	reg_byte_t rd_data;
	reg_code_t rd_code;
	reg_code_t code;
	logic frame_ok;
	logic commit_wr;
	logic commit_rd;
	reg_byte_t act1_q;
	reg_byte_t fwol_q;
	logic [`FREEWHEEL_WIDTH-1:0] fw_q;
	reg_byte_t gstat_q;
	reg_byte_t oc_q [0:2];
	reg_byte_t ol_q [0:2];
	logic [3:0] hs_q;
	logic [3:0] ls_q;
	logic sdo_oe_q;

	assign raw_in = {ol_fault_in, oc_fault_in, global_fault_in, spi_cs_n_in, spi_sclk_in, spi_sdi_in};

	// a level is taken once the second and third stage agree, so a single glitch never counts
	assign filt_d = (~(s2_q ^ s3_q) & s2_q) | ((s2_q ^ s3_q) & filt_q);

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			s1_q <= `SYNC_RESET;
			s2_q <= `SYNC_RESET;
			s3_q <= `SYNC_RESET;
			filt_q <= `SYNC_RESET;
			// edge history starts at the idle levels, so no false edge follows reset
			sclk_prev_q <= 1'b0;
			cs_n_prev_q <= 1'b1;
		end
		else
		begin
			s1_q <= raw_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			filt_q <= filt_d;
			sclk_prev_q <= sclk;
			cs_n_prev_q <= cs_n;
		end
	end

	assign cs_n = filt_q[`SYNC_CS_N];
	assign sclk = filt_q[`SYNC_SCLK];
	assign sdi = filt_q[`SYNC_SDI];

	assign sclk_rise = sclk & ~sclk_prev_q & ~cs_n;
	assign sclk_fall = ~sclk & sclk_prev_q & ~cs_n;
	assign cs_fall = ~cs_n & cs_n_prev_q;
	assign cs_rise = cs_n & ~cs_n_prev_q;

	// short or long frames are dropped whole and flagged
	assign frame_ok = (cnt_q == `FRAME_BITS); // RULE2
	assign code = addr_q[`CODE_HI:`CODE_LO];
	assign commit_wr = cs_rise & frame_ok & addr_q[`OP_BIT]; // RULE5
	assign commit_rd = cs_rise & frame_ok & ~addr_q[`OP_BIT]; // RULE4

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			cnt_q <= 5'h00;
			rx_q <= 8'h00;
			addr_q <= 8'h00;
		end
		else if (cs_fall)
		begin
			cnt_q <= 5'h00;
		end
		else if (sclk_rise)
		begin
			if (cnt_q != 5'h1F)
			begin
				cnt_q <= cnt_q + 5'h01;
			end
			rx_q <= {rx_q[6:0], sdi};
			if (cnt_q == `ADDR_BITS - 5'h01)
			begin
				addr_q <= {rx_q[6:0], sdi}; // RULE2
			end
		end
	end

	assign rd_code = rx_q[`CODE_HI-1:`CODE_LO-1];

	always_comb
	begin
		case (rd_code)
			`CODE_OUTPUT_ACTIVATION_1: rd_data = act1_q;
			`CODE_FREEWHEEL_OPENLOAD: rd_data = fwol_q;
			`CODE_FREEWHEEL: rd_data = {2'h0, fw_q};
			`CODE_DEVICE_CONFIG_ID: rd_data = {5'h00, PART_IDENTIFIER};
			`CODE_GLOBAL_STATUS: rd_data = gstat_q;
			`CODE_OVERCURRENT_A: rd_data = oc_q[0];
			`CODE_OVERCURRENT_B: rd_data = oc_q[1];
			`CODE_OVERCURRENT_C: rd_data = oc_q[2];
			`CODE_OPEN_LOAD_A: rd_data = ol_q[0];
			`CODE_OPEN_LOAD_B: rd_data = ol_q[1];
			`CODE_OPEN_LOAD_C: rd_data = ol_q[2];
			default: rd_data = 8'h00;
		endcase
	end

	// global status leaves first; the addressed register is slotted in at the eighth rising edge,
	// ahead of the falling edge that presents its top bit
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			tx_q <= 16'h0000;
			sdo_oe_q <= 1'b0;
		end
		else
		begin
			sdo_oe_q <= ~cs_n;
			if (cs_fall)
			begin
				tx_q <= {gstat_q, 8'h00};
			end
			else if (sclk_rise && cnt_q == `ADDR_BITS - 5'h01)
			begin
				tx_q[14:7] <= rd_data;
			end
			else if (sclk_fall)
			begin
				tx_q <= {tx_q[14:0], 1'b0};
			end
		end
	end

	assign spi_sdo_out = tx_q[15];
	assign spi_sdo_oe_out = sdo_oe_q;

	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			act1_q <= `CTRL_RESET; // RULE1
			fwol_q <= `CTRL_RESET; // RULE1
			fw_q <= `FREEWHEEL_RESET; // RULE1
		end
		else if (commit_wr) // RULE3
		begin
			if (code == `CODE_OUTPUT_ACTIVATION_1)
			begin
				act1_q <= rx_q; // RULE5
			end
			if (code == `CODE_FREEWHEEL_OPENLOAD)
			begin
				fwol_q <= rx_q; // RULE5
			end
			if (code == `CODE_FREEWHEEL)
			begin
				fw_q <= rx_q[`FREEWHEEL_WIDTH-1:0]; // RULE5
			end
		end
	end

	// switch drive: pairs with both enables set are forced off
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			hs_q <= 4'h0;
			ls_q <= 4'h0;
		end
		else
		begin
			for (int k = 0; k < 4; k++)
			begin
				hs_q[k] <= act1_q[2*k+1] & ~act1_q[2*k]; // RULE6 RULE7 RULE9
				ls_q[k] <= act1_q[2*k] & ~act1_q[2*k+1]; // RULE6 RULE8 RULE9
			end
		end
	end

	assign high_switch_on_out = hs_q;
	assign low_switch_on_out = ls_q;
	assign freewheel_openload_out = fwol_q;
	assign freewheel_out = fw_q;

	// fault set wins over a read clear in the same cycle
	always_ff @(posedge clk_in or posedge rst_in)
	begin
		if (rst_in)
		begin
			gstat_q <= `GLOBAL_STATUS_RESET;
		end
		else
		begin
			gstat_q[0] <= 1'b0;
			gstat_q[6:1] <= ((commit_rd && code == `CODE_GLOBAL_STATUS) ? 6'h00 : gstat_q[6:1])
				| filt_q[`SYNC_GLOBAL_LO +: 6]; // RULE14
			gstat_q[`SPI_ERROR_BIT] <= (cs_rise & ~frame_ok)
				| (gstat_q[`SPI_ERROR_BIT] & ~(commit_rd && code == `CODE_GLOBAL_STATUS));
		end
	end

	genvar g;
	generate
		for (g = 0; g < 3; g++)
		begin : g_diag
			localparam reg_code_t OC_CODE = (g == 0) ? `CODE_OVERCURRENT_A :
				(g == 1) ? `CODE_OVERCURRENT_B : `CODE_OVERCURRENT_C;
			localparam reg_code_t OL_CODE = (g == 0) ? `CODE_OPEN_LOAD_A :
				(g == 1) ? `CODE_OPEN_LOAD_B : `CODE_OPEN_LOAD_C;
			logic oc_clr;
			logic ol_clr;
			assign oc_clr = commit_rd && code == OC_CODE; // RULE10 RULE11
			assign ol_clr = commit_rd && code == OL_CODE; // RULE12 RULE13

			always_ff @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					oc_q[g] <= `STATUS_RESET;
				end
				else
				begin
					oc_q[g] <= (oc_clr ? 8'h00 : oc_q[g]) | filt_q[`SYNC_OC_LO + 8*g +: 8]; // RULE10 RULE11 RULE14
				end
			end

			always_ff @(posedge clk_in or posedge rst_in)
			begin
				if (rst_in)
				begin
					ol_q[g] <= `STATUS_RESET;
				end
				else
				begin
					ol_q[g] <= (ol_clr ? 8'h00 : ol_q[g]) | filt_q[`SYNC_OL_LO + 8*g +: 8]; // RULE12 RULE13 RULE14
				end
			end
		end
	endgenerate

	a_ctl_reset: assert property (@(posedge clk_in) $fell(rst_in) |->
		(act1_q == 8'h00 && fwol_q == 8'h00 && fw_q == 6'h00)) // RULE1
		else $error("control registers not zero after reset");
	a_frame_len: assert property (@(posedge clk_in) disable iff (rst_in)
		$changed(act1_q) |-> $past(cs_rise) && $past(cnt_q) == 5'h10) // RULE2
		else $error("register written by a frame not sixteen bits long");
	a_ctl_hold: assert property (@(posedge clk_in) disable iff (rst_in)
		!$past(commit_wr) |-> $stable(fwol_q) && $stable(fw_q)) // RULE3
		else $error("control register changed without a host write");
	a_read_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
		commit_rd |=> $stable(act1_q)) // RULE4
		else $error("read access modified a control register");
	a_write_stores: assert property (@(posedge clk_in) disable iff (rst_in)
		commit_wr && code == 5'h00 |=> act1_q == $past(rx_q)) // RULE5
		else $error("write data not stored");
	a_high_drive: assert property (@(posedge clk_in) disable iff (rst_in)
		high_switch_on_out[3] == $past(act1_q[7] & ~act1_q[6])) // RULE6 RULE7
		else $error("high switch of output 4 does not follow its enable");
	a_low_drive: assert property (@(posedge clk_in) disable iff (rst_in)
		low_switch_on_out[0] == $past(act1_q[0] & ~act1_q[1])) // RULE6 RULE8
		else $error("low switch of output 1 does not follow its enable");
	a_cross_off: assert property (@(posedge clk_in) disable iff (rst_in)
		(high_switch_on_out & low_switch_on_out) == 4'h0) // RULE9
		else $error("both switches of a half-bridge on");
	a_oc_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		commit_rd && code == 5'h16 && filt_q[16:9] == 8'h00 |=> oc_q[0] == 8'h00) // RULE10
		else $error("overcurrent status a not cleared by read");
	a_oc_c_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		filt_q[32] |=> oc_q[2][7]) // RULE11
		else $error("output 12 high overcurrent not flagged");
	a_ol_clear: assert property (@(posedge clk_in) disable iff (rst_in)
		commit_rd && code == 5'h01 && filt_q[40:33] == 8'h00 |=> ol_q[0] == 8'h00) // RULE12
		else $error("open-load status a not cleared by read");
	a_ol_bc_flag: assert property (@(posedge clk_in) disable iff (rst_in)
		filt_q[41] && filt_q[56] |=> ol_q[1][0] && ol_q[2][7]) // RULE13
		else $error("open-load flag of outputs 5 to 12 missing");
	a_fault_reset: assert property (@(posedge clk_in) disable iff (rst_in)
		commit_rd && filt_q[9] |=> oc_q[0][0]) // RULE14
		else $error("persisting fault lost by read clear");

endmodule : half_bridge_spi_register_bank

// ---- half_bridge_cfg.svh ----
`ifndef HALF_BRIDGE_CFG_SVH
`define HALF_BRIDGE_CFG_SVH

// serial frame
`define FRAME_BITS 5'h10
`define ADDR_BITS 5'h08
`define OP_BIT 7
`define CODE_HI 6
`define CODE_LO 2

// register codes, address byte bits 6..2
`define CODE_OUTPUT_ACTIVATION_1 5'h00
`define CODE_FREEWHEEL_OPENLOAD 5'h0A
`define CODE_FREEWHEEL 5'h1A
`define CODE_DEVICE_CONFIG_ID 5'h19
`define CODE_GLOBAL_STATUS 5'h06
`define CODE_OVERCURRENT_A 5'h16
`define CODE_OVERCURRENT_B 5'h0E
`define CODE_OVERCURRENT_C 5'h1E
`define CODE_OPEN_LOAD_A 5'h01
`define CODE_OPEN_LOAD_B 5'h11
`define CODE_OPEN_LOAD_C 5'h09

// reset values
`define CTRL_RESET 8'h00
`define STATUS_RESET 8'h00
`define GLOBAL_STATUS_RESET 8'h08
`define FREEWHEEL_RESET 6'h00

// field positions
`define SPI_ERROR_BIT 7
`define FREEWHEEL_WIDTH 6
`define ID_WIDTH 3

// synchroniser layout
`define SYNC_SDI 0
`define SYNC_SCLK 1
`define SYNC_CS_N 2
`define SYNC_GLOBAL_LO 3
`define SYNC_OC_LO 9
`define SYNC_OL_LO 33
`define SYNC_WIDTH 57
`define SYNC_RESET 57'h000000000000004

`endif

// ---- half_bridge_pkg.sv ----
package half_bridge_pkg;
	typedef logic [7:0] reg_byte_t;
	typedef logic [4:0] reg_code_t;
	typedef logic [4:0] bit_count_t;
endpackage : half_bridge_pkg

// ---- spi_host_model.sv ----
`timescale 1ns/1ps

module spi_host_model
(
	input wire logic clk_in,
	output logic cs_n_out,
	output logic sclk_out,
	output logic sdi_out,
	input wire logic sdo_in
);
	// sclk stands low outside frames; half period of 8 clocks leaves room for the input synchroniser
	initial
	begin
		cs_n_out = 1'b1;
		sclk_out = 1'b0;
		sdi_out = 1'b0;
	end

	task automatic wait_clk(input int n);
		repeat (n) @(posedge clk_in);
		#1;
	endtask : wait_clk

	// address byte first, then data byte, msb first
	task automatic frame(input logic [15:0] word, input int nbits, output logic [7:0] rdata);
		logic [15:0] got;
		got = 16'h0000;
		cs_n_out = 1'b0;
		wait_clk(8);
		for (int i = 0; i < nbits; i++)
		begin
			sdi_out = word[15 - i];
			wait_clk(8);
			got = {got[14:0], sdo_in};
			sclk_out = 1'b1;
			wait_clk(8);
			sclk_out = 1'b0;
		end
		wait_clk(8);
		cs_n_out = 1'b1;
		// a released data line does not keep its last level
		sdi_out = ~sdi_out;
		wait_clk(12);
		rdata = got[7:0];
	endtask : frame
endmodule : spi_host_model

// ---- half_bridge_spi_register_bank_test.sv ----
`timescale 1ns/1ps
`include "half_bridge_cfg.svh"

module half_bridge_spi_register_bank_test
	import half_bridge_pkg::*;
;
	logic clk_in = 1'b0;
	logic rst_in = 1'b1;
	logic spi_cs_n, spi_sclk, spi_sdi, spi_sdo;
	logic spi_sdo_oe;
	logic [5:0] global_fault_in = 6'h00;
	logic [23:0] oc_fault_in = 24'h000000;
	logic [23:0] ol_fault_in = 24'h000000;
	logic [3:0] high_switch_on_out, low_switch_on_out;
	logic [7:0] freewheel_openload_out;
	logic [5:0] freewheel_out;
	int n_fail = 0;
	int tests_run = 0;
	reg_byte_t rd, v, w, prev;
	reg_code_t codes [6] = '{`CODE_OVERCURRENT_A, `CODE_OVERCURRENT_B, `CODE_OVERCURRENT_C,
		`CODE_OPEN_LOAD_A, `CODE_OPEN_LOAD_B, `CODE_OPEN_LOAD_C};
	reg_byte_t corner [4] = '{8'h03, 8'hFF, 8'hAA, 8'h55};

	always #2 clk_in = ~clk_in;

	half_bridge_spi_register_bank #(.PART_IDENTIFIER(3'h5)) dut (
		.clk_in(clk_in),
		.rst_in(rst_in),
		.spi_cs_n_in(spi_cs_n),
		.spi_sclk_in(spi_sclk),
		.spi_sdi_in(spi_sdi),
		.spi_sdo_out(spi_sdo),
		.spi_sdo_oe_out(spi_sdo_oe),
		.global_fault_in(global_fault_in),
		.oc_fault_in(oc_fault_in),
		.ol_fault_in(ol_fault_in),
		.high_switch_on_out(high_switch_on_out),
		.low_switch_on_out(low_switch_on_out),
		.freewheel_openload_out(freewheel_openload_out),
		.freewheel_out(freewheel_out)
	);

	spi_host_model host (
		.clk_in(clk_in),
		.cs_n_out(spi_cs_n),
		.sclk_out(spi_sclk),
		.sdi_out(spi_sdi),
		.sdo_in(spi_sdo)
	);

	// pairs: low enable in the even bit, high enable in the odd bit; both set means both off
	function automatic reg_byte_t exp_sw(input reg_byte_t a);
		reg_byte_t r;
		r = 8'h00;
		for (int k = 0; k < 4; k++)
		begin
			r[4 + k] = a[2 * k + 1] & ~a[2 * k];
			r[k] = a[2 * k] & ~a[2 * k + 1];
		end
		return r;
	endfunction : exp_sw

	task automatic check(input reg_byte_t got, input reg_byte_t exp);
		tests_run++;
		if (got !== exp)
		begin
			n_fail++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : check

	task automatic rw(input logic op, input reg_code_t code, input reg_byte_t data, output reg_byte_t r);
		host.frame({op, code, 2'b01, data}, 16, r);
	endtask : rw

	task automatic complete_run();
		$display("comparisons %0d mismatches %0d", tests_run, n_fail);
		if (n_fail == 0 && tests_run > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : complete_run

	initial
	begin
		// a full run is about 61 frames of some 300 clocks each; twice that leaves margin
		repeat (40000) @(posedge clk_in);
		n_fail++;
		complete_run();
	end

	initial
	begin
		void'($urandom(32'h4E9474AD));
		repeat (8) @(posedge clk_in);
		#1;
		rst_in = 1'b0;
		host.wait_clk(4);
		check({high_switch_on_out, low_switch_on_out}, 8'h00);
		check(freewheel_openload_out, 8'h00);
		check({2'b00, freewheel_out}, 8'h00);
		check({7'h00, spi_sdo_oe}, 8'h00);
		rw(1'b0, `CODE_FREEWHEEL, 8'h00, rd);
		check(rd, 8'h00);
		rw(1'b0, `CODE_OUTPUT_ACTIVATION_1, 8'hFF, rd);
		check(rd, 8'h00);
		$display("test reset values done");
		prev = 8'h00;
		for (int i = 0; i < 12; i++)
		begin
			v = (i < 4) ? corner[i] : reg_byte_t'($urandom);
			rw(1'b1, `CODE_OUTPUT_ACTIVATION_1, v, rd);
			check(rd, prev);
			check({high_switch_on_out, low_switch_on_out}, exp_sw(v));
			rw(1'b0, `CODE_OUTPUT_ACTIVATION_1, ~v, rd);
			check(rd, v);
			check({high_switch_on_out, low_switch_on_out}, exp_sw(v));
			prev = v;
		end
		$display("test switch enables done");
		v = reg_byte_t'($urandom);
		w = reg_byte_t'($urandom);
		rw(1'b1, `CODE_FREEWHEEL_OPENLOAD, v, rd);
		rw(1'b1, `CODE_FREEWHEEL, w, rd);
		check(freewheel_openload_out, v);
		check({2'b00, freewheel_out}, {2'b00, w[5:0]});
		rw(1'b0, `CODE_FREEWHEEL_OPENLOAD, 8'h00, rd);
		check(rd, v);
		rw(1'b1, `CODE_DEVICE_CONFIG_ID, 8'hFF, rd);
		rw(1'b0, `CODE_DEVICE_CONFIG_ID, 8'h00, rd);
		check(rd, 8'h05);
		check({high_switch_on_out, low_switch_on_out}, exp_sw(prev));
		$display("test freewheel and config done");
		for (int pass = 0; pass < 2; pass++)
		begin
			// the second pass pins the corner flags that the end-of-range checks watch
			oc_fault_in = 24'($urandom) | ((pass == 1) ? 24'h800001 : 24'h000000);
			ol_fault_in = 24'($urandom) | ((pass == 1) ? 24'h800100 : 24'h000000);
			host.wait_clk(10);
			// first pass: faults gone before the reads, so flags must clear; second pass: faults stay
			if (pass == 0)
			begin
				w = oc_fault_in[7:0];
				oc_fault_in = 24'h000000;
				ol_fault_in = 24'h000000;
				host.wait_clk(10);
			end
			for (int r = 0; r < 6; r++)
			begin
				v = (pass == 0) ? 8'h00 : (r < 3) ? oc_fault_in[8 * r +: 8] : ol_fault_in[8 * (r - 3) +: 8];
				rw(1'b0, codes[r], 8'h00, rd);
				if (pass == 0 && r == 0)
					check(rd, w);
				rw(1'b0, codes[r], 8'h00, rd);
				check(rd, v);
			end
		end
		oc_fault_in = 24'h000000;
		ol_fault_in = 24'h000000;
		$display("test status flags done");
		host.frame({1'b1, `CODE_OUTPUT_ACTIVATION_1, 2'b01, ~prev}, 15, rd);
		fork
			rw(1'b0, `CODE_OUTPUT_ACTIVATION_1, 8'h00, rd);
			begin
				host.wait_clk(20);
				check({7'h00, spi_sdo_oe}, 8'h01);
			end
		join
		check(rd, prev);
		rw(1'b0, `CODE_GLOBAL_STATUS, 8'h00, rd);
		// spi error from the cut frame and the power-on flag, neither read before
		check(rd, 8'h88);
		rw(1'b0, `CODE_GLOBAL_STATUS, 8'h00, rd);
		check(rd, 8'h00);
		rw(1'b0, 5'h1F, 8'h00, rd);
		check(rd, 8'h00);
		check({7'h00, spi_sdo_oe}, 8'h00);
		$display("test short frame done");
		w = reg_byte_t'($urandom);
		global_fault_in = w[5:0];
		host.wait_clk(10);
		rw(1'b0, `CODE_GLOBAL_STATUS, 8'h00, rd);
		check(rd, {1'b0, w[5:0], 1'b0});
		global_fault_in = 6'h00;
		$display("test global faults done");
		complete_run();
	end
endmodule : half_bridge_spi_register_bank_test
